// [core/lsl_cfg.svh]
// constants of the low speed command link: timing, register map, field layout
// assumes one system clock of 250 MHz; included by the package and the modules
`ifndef LSL_CFG_SVH
`define LSL_CFG_SVH
`define LSL_CLK_KHZ 250000
`define LSL_CLK_PERIOD_PS 4000
`define LSL_LINK_HZ 312500
`define LSL_HALF_CYC ((`LSL_CLK_KHZ * 1000) / (2 * `LSL_LINK_HZ))
`define LSL_HALF_W 9
`define LSL_GAP_NS 10000
`define LSL_GAP_CYC ((`LSL_GAP_NS * 1000 + `LSL_CLK_PERIOD_PS - 1) / `LSL_CLK_PERIOD_PS)
`define LSL_GAP_W 12
`define LSL_TMO_US 700
`define LSL_TMO_CYC ((`LSL_TMO_US * `LSL_CLK_KHZ) / 1000)
`define LSL_TMO_W 18
`define LSL_WORD_BITS 32
`define LSL_FRAME_BITS 33
`define LSL_CNT_W 6
`define LSL_STOP_LEVEL 1'b0
`define LSL_IDLE_LEVEL 1'b0
`define LSL_BIT_FIRST_START_BIT 31
`define LSL_BIT_SECOND_START_BIT 30
`define LSL_BIT_ADDR_FIRST 29
`define LSL_BIT_ADDR_SECOND 28
`define LSL_ADDR_W 24
`define LSL_OFS_TX 24'h00_0000
`define LSL_OFS_RX 24'h00_0001
`define LSL_OFS_STATUS 24'h00_0002
`define LSL_ST_BUSY 0
`define LSL_ST_READY 1
`define LSL_ST_HKPEND 2
`define LSL_ST_TIMEOUT 3
`define LSL_ST_ABORT 4
`define LSL_ZERO_WORD 32'h0000_0000
`endif

// [core/lsl_pkg.sv]
// types shared by the low speed link modules
// assumes lsl_cfg.svh is on the include path
`include "lsl_cfg.svh"
package lsl_pkg;
  typedef enum logic [3:0] {
    LSL_IDLE = 4'b0001,
    LSL_SEND = 4'b0010,
    LSL_WAIT = 4'b0100,
    LSL_GAP = 4'b1000
  } lsl_state_t;

  typedef logic [`LSL_WORD_BITS-1:0] lsl_word_t;

  typedef struct packed {
    logic [`LSL_HALF_W-1:0] cnt;
    logic lineClk;
    logic rise;
    logic fall;
  } lsl_div_t;

  typedef struct packed {
    logic started;
    logic [`LSL_CNT_W-1:0] cnt;
    lsl_word_t shift;
    lsl_word_t word;
    logic done;
  } lsl_rx_t;

  // a second start bit of zero asks for a housekeeping reply
  function automatic logic lsl_is_hk(input lsl_word_t w);
    lsl_is_hk = ~w[`LSL_BIT_SECOND_START_BIT];
  endfunction : lsl_is_hk

  function automatic logic [1:0] lsl_addr_of(input lsl_word_t w);
    lsl_addr_of = {w[`LSL_BIT_ADDR_FIRST], w[`LSL_BIT_ADDR_SECOND]};
  endfunction : lsl_addr_of
endpackage : lsl_pkg

// [core/lsl_core_if.sv]
// carrier between the link core and its divider and receiver
// assumes all members are driven on clk_sys
`timescale 1ns/100ps
interface lsl_core_if;
  import lsl_pkg::*;
  logic clear;
  logic linkClk;
  logic riseTick;
  logic fallTick;
  logic rxArm;
  logic rxBit;
  logic rxDone;
  lsl_word_t rxWord;
  modport div (input clear, output linkClk, output riseTick, output fallTick);
  modport rx (input clear, input riseTick, input rxArm, input rxBit, output rxDone, output rxWord);
  modport core (output clear, output rxArm, output rxBit, input linkClk, input riseTick,
                input fallTick, input rxDone, input rxWord);
endinterface : lsl_core_if

// [core/lsl_clk_div.sv]
// link clock divider: free running square wave with one-cycle edge pulses
// assumes clear is a same-domain level that restarts the divider
`timescale 1ns/100ps
`include "lsl_cfg.svh"
module lsl_clk_div
  import lsl_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_b,
  lsl_core_if.div ifc
);
  lsl_div_t r_reg, r_next;

  always_comb begin
    r_next = r_reg;
    r_next.rise = 1'b0;
    r_next.fall = 1'b0;
    if (r_reg.cnt == `LSL_HALF_W'(`LSL_HALF_CYC - 1)) begin
      r_next.cnt = '0;
      r_next.lineClk = ~r_reg.lineClk;
      r_next.rise = ~r_reg.lineClk;
      r_next.fall = r_reg.lineClk;
    end else begin
      r_next.cnt = r_reg.cnt + `LSL_HALF_W'(1);
    end
    if (ifc.clear) begin
      r_next = '0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign ifc.linkClk = r_reg.lineClk;
  assign ifc.riseTick = r_reg.rise;
  assign ifc.fallTick = r_reg.fall;
endmodule : lsl_clk_div

// [core/lsl_rx_deser.sv]
// response receiver: hunts for the first start bit, then gathers one word
// assumes rxBit is already synchronised and rxArm drops between responses
`timescale 1ns/100ps
`include "lsl_cfg.svh"
module lsl_rx_deser
  import lsl_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_b,
  lsl_core_if.rx ifc
);
  lsl_rx_t r_reg, r_next;

  always_comb begin
    r_next = r_reg;
    r_next.done = 1'b0;
    if (!ifc.rxArm || ifc.clear) begin
      r_next.started = 1'b0;
      r_next.cnt = '0;
    end else if (ifc.riseTick && r_reg.cnt != `LSL_CNT_W'(`LSL_WORD_BITS)) begin
      if (!r_reg.started) begin
        if (ifc.rxBit) begin
          r_next.started = 1'b1;
          r_next.shift = lsl_word_t'(1);
          r_next.cnt = `LSL_CNT_W'(1);
        end
      end else begin
        r_next.shift = {r_reg.shift[`LSL_WORD_BITS-2:0], ifc.rxBit};
        r_next.cnt = r_reg.cnt + `LSL_CNT_W'(1);
        // the stop bit is not gathered; the word is complete after 32 bits
        if (r_reg.cnt == `LSL_CNT_W'(`LSL_WORD_BITS - 1)) begin
          r_next.word = {r_reg.shift[`LSL_WORD_BITS-2:0], ifc.rxBit};
          r_next.done = 1'b1;
        end
      end
    end
    if (ifc.clear) begin
      r_next.word = '0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign ifc.rxDone = r_reg.done;
  assign ifc.rxWord = r_reg.word;
endmodule : lsl_rx_deser

// [core/lsl_link_top.sv]
// low speed command link, master end: bus registers, frame sender, response wait
// assumes the bus strobes and linkResetFlag come from logic on clk_sys
`timescale 1ns/100ps
`include "lsl_cfg.svh"
module lsl_link_top
  import lsl_pkg::*;
#(
  parameter logic [`LSL_TMO_W-1:0] TIMEOUT_CYCLES = `LSL_TMO_W'(`LSL_TMO_CYC)
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic linkResetFlag,
  input wire logic cs4_b,
  input wire logic rd_b,
  input wire logic wr_b,
  input wire logic [`LSL_ADDR_W-1:0] busAddr,
  input wire logic [`LSL_WORD_BITS-1:0] busDataIn,
  output logic [`LSL_WORD_BITS-1:0] busDataOut,
  output logic busDataOe,
  output logic busAck,
  output logic linkClockLine,
  output logic linkTransmitLine,
  input wire logic linkReceiveLine0,
  input wire logic linkReceiveLine1
);

  typedef struct packed {
    lsl_state_t state;
    lsl_word_t txWord;
    logic txPend;
    logic [`LSL_FRAME_BITS-1:0] shift;
    logic [`LSL_CNT_W-1:0] bitCnt;
    logic txLine;
    logic rxSel;
    lsl_word_t rxWord;
    logic dataReady;
    logic hkPending;
    logic timeoutFlag;
    logic abortFlag;
    logic [`LSL_TMO_W-1:0] tmoCnt;
    logic [`LSL_GAP_W-1:0] gapCnt;
    logic busAct;
    logic ack;
    logic rdOe;
    lsl_word_t rdData;
    logic [1:0] rx0Sync;
    logic [1:0] rx1Sync;
  } lsl_top_t;

  lsl_top_t r_reg, r_next;
  lsl_core_if linkIf ();

  ////////////////////////////////////////////////////////////////////////////
  // divider and receiver

  lsl_clk_div i_lsl_clk_div (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .ifc(linkIf.div)
  );

  lsl_rx_deser i_lsl_rx_deser (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .ifc(linkIf.rx)
  );

  assign linkIf.clear = linkResetFlag;
  assign linkIf.rxArm = (r_reg.state == LSL_WAIT);
  // only the second stage of either synchroniser reaches the mux
  assign linkIf.rxBit = r_reg.rxSel ? r_reg.rx1Sync[1] : r_reg.rx0Sync[1];

  ////////////////////////////////////////////////////////////////////////////
  // bus decode

  logic sel;
  logic take;
  logic isRead;
  logic isWrite;
  logic busy;
  lsl_word_t statusWord;
  logic [`LSL_FRAME_BITS-1:0] frame;

  // chip select may stay low across accesses, so a new access is a fresh strobe
  assign sel = ~cs4_b & (~rd_b | ~wr_b);
  assign take = sel & ~r_reg.busAct;
  assign isRead = take & ~rd_b;
  assign isWrite = take & ~wr_b & rd_b;
  assign busy = (r_reg.state == LSL_SEND);

  always_comb begin
    statusWord = `LSL_ZERO_WORD;
    statusWord[`LSL_ST_BUSY] = busy;
    statusWord[`LSL_ST_READY] = r_reg.dataReady;
    statusWord[`LSL_ST_HKPEND] = r_reg.hkPending;
    statusWord[`LSL_ST_TIMEOUT] = r_reg.timeoutFlag;
    statusWord[`LSL_ST_ABORT] = r_reg.abortFlag;
  end

  // first start bit forced high; stop bit appended by hardware
  always_comb begin
    frame = {r_reg.txWord, `LSL_STOP_LEVEL};
    frame[`LSL_BIT_FIRST_START_BIT + 1] = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    r_next = r_reg;
    r_next.ack = 1'b0;
    r_next.rx0Sync = {r_reg.rx0Sync[0], linkReceiveLine0};
    r_next.rx1Sync = {r_reg.rx1Sync[0], linkReceiveLine1};
    r_next.busAct = sel;

    // register reads; clearing effects come first so hardware sets win
    if (take) begin
      r_next.ack = 1'b1;
      r_next.rdOe = isRead;
    end
    if (isRead) begin
      case (busAddr)
        `LSL_OFS_TX: r_next.rdData = r_reg.txWord;
        `LSL_OFS_RX: begin
          r_next.rdData = r_reg.rxWord;
          r_next.rxWord = `LSL_ZERO_WORD;
          r_next.dataReady = 1'b0;
        end
        `LSL_OFS_STATUS: begin
          r_next.rdData = statusWord;
          r_next.timeoutFlag = 1'b0;
          r_next.abortFlag = 1'b0;
        end
        default: r_next.rdData = `LSL_ZERO_WORD;
      endcase
    end

    // a write during a frame is dropped: software must wait for busy to clear
    if (isWrite && busAddr == `LSL_OFS_TX && !busy) begin
      r_next.txWord = busDataIn;
      r_next.txPend = 1'b1;
      r_next.dataReady = 1'b0;
      r_next.hkPending = 1'b0;
      r_next.timeoutFlag = 1'b0;
      if (lsl_is_hk(busDataIn)) begin
        // a newer request replaces an unsent one or ends a wait
        if ((r_reg.txPend && lsl_is_hk(r_reg.txWord)) || r_reg.state == LSL_WAIT) begin
          r_next.abortFlag = 1'b1;
        end
        if (r_reg.state == LSL_WAIT) begin
          r_next.state = LSL_GAP;
          r_next.gapCnt = '0;
        end
      end
    end

    case (r_reg.state)
      LSL_IDLE: begin
        // starting on a falling edge keeps every line change on that edge
        if (r_reg.txPend && linkIf.fallTick) begin
          r_next.state = LSL_SEND;
          r_next.txPend = 1'b0;
          r_next.txLine = frame[`LSL_FRAME_BITS-1];
          r_next.shift = {frame[`LSL_FRAME_BITS-2:0], 1'b0};
          r_next.bitCnt = `LSL_CNT_W'(1);
          r_next.rxSel = r_reg.txWord[`LSL_BIT_ADDR_FIRST];
        end
      end
      LSL_SEND: begin
        if (linkIf.fallTick) begin
          if (r_reg.bitCnt == `LSL_CNT_W'(`LSL_FRAME_BITS)) begin
            r_next.txLine = `LSL_IDLE_LEVEL;
            r_next.gapCnt = '0;
            r_next.tmoCnt = '0;
            if (lsl_is_hk(r_reg.txWord)) begin
              r_next.state = LSL_WAIT;
              r_next.hkPending = 1'b1;
            end else begin
              r_next.state = LSL_GAP;
            end
          end else begin
            r_next.txLine = r_reg.shift[`LSL_FRAME_BITS-1];
            r_next.shift = {r_reg.shift[`LSL_FRAME_BITS-2:0], 1'b0};
            r_next.bitCnt = r_reg.bitCnt + `LSL_CNT_W'(1);
          end
        end
      end
      LSL_WAIT: begin
        // nothing else starts here, so no other unit is addressed meanwhile
        if (r_reg.txPend) begin
          r_next.txPend = 1'b1;
        end
        if (linkIf.rxDone) begin
          r_next.rxWord = linkIf.rxWord;
          r_next.dataReady = 1'b1;
          r_next.hkPending = 1'b0;
          r_next.state = LSL_GAP;
          r_next.gapCnt = '0;
        end else if (r_reg.tmoCnt == TIMEOUT_CYCLES - `LSL_TMO_W'(1)) begin
          r_next.timeoutFlag = 1'b1;
          r_next.hkPending = 1'b0;
          r_next.state = LSL_GAP;
          r_next.gapCnt = '0;
        end else begin
          r_next.tmoCnt = r_reg.tmoCnt + `LSL_TMO_W'(1);
        end
      end
      LSL_GAP: begin
        // spacing covers both the 10 us command gap and one link period
        if (r_reg.gapCnt == `LSL_GAP_W'(`LSL_GAP_CYC - 1)) begin
          r_next.state = LSL_IDLE;
        end else begin
          r_next.gapCnt = r_reg.gapCnt + `LSL_GAP_W'(1);
        end
      end
      default: begin
        r_next.state = LSL_IDLE;
      end
    endcase

    // link reset: a held level, so the link stays cleared until released
    if (linkResetFlag) begin
      r_next.state = LSL_IDLE;
      r_next.txWord = `LSL_ZERO_WORD;
      r_next.txPend = 1'b0;
      r_next.shift = '0;
      r_next.bitCnt = '0;
      r_next.txLine = `LSL_IDLE_LEVEL;
      r_next.rxSel = 1'b0;
      r_next.rxWord = `LSL_ZERO_WORD;
      r_next.dataReady = 1'b0;
      r_next.hkPending = 1'b0;
      r_next.timeoutFlag = 1'b0;
      r_next.abortFlag = 1'b0;
      r_next.tmoCnt = '0;
      r_next.gapCnt = '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      r_reg <= '0;
      r_reg.state <= LSL_IDLE;
    end else begin
      r_reg <= r_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign busAck = r_reg.ack;
  assign busDataOut = r_reg.rdData;
  assign busDataOe = r_reg.ack & r_reg.rdOe;
  assign linkClockLine = linkIf.linkClk;
  assign linkTransmitLine = r_reg.txLine;
endmodule : lsl_link_top

// [testbench/lsl_link_checker.sv]
// checker of bus handshake and link line timing
// assumes it is bound to lsl_link_top and sees only its ports
`timescale 1ns/100ps
`include "lsl_cfg.svh"
module lsl_link_checker
  import lsl_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic linkResetFlag,
  input wire logic cs4_b,
  input wire logic rd_b,
  input wire logic wr_b,
  input wire logic [`LSL_ADDR_W-1:0] busAddr,
  input wire logic [`LSL_WORD_BITS-1:0] busDataOut,
  input wire logic busDataOe,
  input wire logic busAck,
  input wire logic linkClockLine,
  input wire logic linkTransmitLine
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  logic [9:0] halfCnt_reg;
  logic armed_reg;
  ////////////////////////////////////////
  // the half period after a link reset is not judged: the divider restarts there
  always_ff @(posedge clk_sys) begin
    if (!rst_b || linkResetFlag) begin
      halfCnt_reg <= 10'h001;
      armed_reg <= 1'b0;
    end else if ($changed(linkClockLine)) begin
      halfCnt_reg <= 10'h001;
      armed_reg <= 1'b1;
    end else begin
      halfCnt_reg <= halfCnt_reg + 10'h001;
    end
  end
  ack_single_pulse_a: assert property (busAck |=> !busAck) else $error("ack too long");
  take_gets_ack_a: assert property (!cs4_b && !(rd_b && wr_b) && $past(rd_b) && $past(wr_b) |=> busAck)
    else $error("no ack");
  ack_needs_select_a: assert property (busAck |-> !$past(cs4_b)) else $error("ack unselected");
  oe_only_read_a: assert property (busDataOe |-> busAck && !$past(rd_b)) else $error("stray enable");
  read_has_oe_a: assert property (busAck && !$past(rd_b) |-> busDataOe) else $error("read no enable");
  unmapped_reads_zero_a: assert property (busAck && !$past(rd_b) && $past(busAddr) > `LSL_OFS_STATUS
    |-> busDataOut == `LSL_ZERO_WORD) else $error("unmapped data");
  tx_on_fall_a: assert property ($changed(linkTransmitLine) |-> !linkClockLine) else $error("tx off fall");
  clock_half_period_a: assert property ($changed(linkClockLine) && armed_reg |-> halfCnt_reg == 10'h190)
    else $error("bad half period");
  link_reset_quiet_a: assert property (linkResetFlag |=> !linkTransmitLine && !linkClockLine)
    else $error("lines not quiet");
  read_cover_c: cover property (busAck && busDataOe);
endmodule : lsl_link_checker

bind lsl_link_top lsl_link_checker i_lsl_link_checker (.clk_sys(clk_sys), .rst_b(rst_b),
  .linkResetFlag(linkResetFlag), .cs4_b(cs4_b), .rd_b(rd_b), .wr_b(wr_b), .busAddr(busAddr),
  .busDataOut(busDataOut), .busDataOe(busDataOe), .busAck(busAck), .linkClockLine(linkClockLine),
  .linkTransmitLine(linkTransmitLine));

// [testbench/lsl_subsys_model.sv]
// model of the three instrument units on the far side of the link
// assumes one model stands for all units and follows the link clock
`timescale 1ns/100ps
module lsl_subsys_model #(
  parameter logic [27:0] REPLY_DATA = 28'h5A3_C1E7
) (
  input wire logic linkClockLine,
  input wire logic linkTransmitLine,
  input wire logic silent,
  output logic linkReceiveLine0,
  output logic linkReceiveLine1
);
  logic [31:0] cmdWord;
  int bitCnt;
  // fail-safe receiver bias keeps released lines low, so idle never looks like a start bit
  initial begin
    linkReceiveLine0 = 1'b0;
    linkReceiveLine1 = 1'b0;
    bitCnt = 0;
  end
  ////////////////////////////////////////
  task automatic sendReply(input logic [1:0] unitAddr);
    logic [32:0] frame;
    frame = {2'b10, unitAddr, REPLY_DATA, 1'b0};
    repeat (3) @(negedge linkClockLine);
    for (int k = 32; k >= 0; k--) begin
      @(negedge linkClockLine);
      {linkReceiveLine1, linkReceiveLine0} = unitAddr[1] ? {frame[k], 1'b0} : {1'b0, frame[k]};
    end
    @(negedge linkClockLine);
    {linkReceiveLine1, linkReceiveLine0} = 2'b00;
  endtask : sendReply
  always begin
    @(posedge linkClockLine);
    if (bitCnt > 0 || linkTransmitLine) begin
      cmdWord = {cmdWord[30:0], linkTransmitLine};
      bitCnt++;
    end
    if (bitCnt == 32) begin
      bitCnt = 0;
      // a broadcast request has no single owner, so nobody answers it
      if (!cmdWord[30] && cmdWord[29:28] != 2'b11 && !silent) sendReply(cmdWord[29:28]);
    end
  end
endmodule : lsl_subsys_model

// [testbench/tb_low_speed_command_link.sv]
// self-checking bench of the link top: registers, frames, replies, timeout, link reset
// assumes the unit model answers housekeeping requests, except broadcasts to address 11, unless told to stay silent
`timescale 1ns/100ps
`include "lsl_cfg.svh"
module tb_low_speed_command_link;
  import lsl_pkg::*;
  localparam logic [27:0] REPLY = 28'h5A3_C1E7;
  localparam lsl_word_t ZERO = `LSL_ZERO_WORD;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic linkResetFlag = 1'b0;
  logic cs4_b = 1'b1;
  logic rd_b = 1'b1;
  logic wr_b = 1'b1;
  logic silent = 1'b0;
  logic [`LSL_ADDR_W-1:0] busAddr = '0;
  lsl_word_t busDataIn = '0;
  lsl_word_t busDataOut;
  logic busDataOe, busAck, linkClockLine, linkTransmitLine, rx0, rx1;
  int bad_count = 0;
  int check_count = 0;
  initial begin
    forever #2 clk_sys = ~clk_sys;
  end
  lsl_link_top #(.TIMEOUT_CYCLES(18'h0_7530)) i_lsl_link_top (.clk_sys(clk_sys), .rst_b(rst_b),
    .linkResetFlag(linkResetFlag), .cs4_b(cs4_b), .rd_b(rd_b), .wr_b(wr_b), .busAddr(busAddr),
    .busDataIn(busDataIn), .busDataOut(busDataOut), .busDataOe(busDataOe), .busAck(busAck),
    .linkClockLine(linkClockLine), .linkTransmitLine(linkTransmitLine),
    .linkReceiveLine0(rx0), .linkReceiveLine1(rx1));
  lsl_subsys_model #(.REPLY_DATA(REPLY)) i_lsl_subsys_model (.linkClockLine(linkClockLine),
    .linkTransmitLine(linkTransmitLine), .silent(silent), .linkReceiveLine0(rx0), .linkReceiveLine1(rx1));
  ////////////////////////////////////////
  task automatic check(input string what, input lsl_word_t seen, input lsl_word_t exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic bus(input logic isWr, input logic [`LSL_ADDR_W-1:0] a, input lsl_word_t d, output lsl_word_t q);
    int n;
    n = 0;
    @(posedge clk_sys);
    cs4_b <= 1'b0;
    busAddr <= a;
    busDataIn <= d;
    wr_b <= !isWr;
    rd_b <= isWr;
    // the answer is taken at the rising edge that sees acknowledge high, then released
    do begin
      @(posedge clk_sys);
      n++;
    end while (busAck !== 1'b1 && n < 8);
    q = busDataOut;
    check("ack", 32'(busAck), 32'h0000_0001);
    check("enable", 32'(busDataOe), 32'(!isWr));
    cs4_b <= 1'b1;
    rd_b <= 1'b1;
    wr_b <= 1'b1;
  endtask : bus
  task automatic rd(input logic [`LSL_ADDR_W-1:0] a, output lsl_word_t q);
    bus(1'b0, a, ZERO, q);
  endtask : rd
  task automatic wrTx(input lsl_word_t d);
    lsl_word_t q;
    bus(1'b1, `LSL_OFS_TX, d, q);
  endtask : wrTx
  // polls until status bit b rises, then judges the whole word
  task automatic waitStatus(input int b, input lsl_word_t exp, input int lim, output lsl_word_t s);
    int n;
    n = 0;
    do begin
      rd(`LSL_OFS_STATUS, s);
      n++;
    end while (s[b] !== 1'b1 && n < lim);
    check("status", s, exp);
  endtask : waitStatus
  ////////////////////////////////////////
  task automatic testRegsAfterReset();
    lsl_word_t q;
    rd(`LSL_OFS_STATUS, q);
    check("status idle", q, ZERO);
    rd(`LSL_OFS_RX, q);
    check("rx idle", q, ZERO);
    bus(1'b1, 24'h00_0005, 32'hFFFF_FFFF, q);
    rd(24'h00_0005, q);
    check("unmapped", q, ZERO);
  endtask : testRegsAfterReset
  task automatic testHkReply();
    lsl_word_t cmd, q;
    logic [32:0] frame;
    int n;
    cmd = {2'b10, 2'b10, 28'h012_3456};
    silent = 1'b0;
    wrTx(cmd);
    n = 0;
    do begin
      @(posedge linkClockLine);
      n++;
    end while (linkTransmitLine !== 1'b1 && n < 4);
    frame[32] = linkTransmitLine;
    rd(`LSL_OFS_STATUS, q);
    check("busy", 32'(q[0]), 32'h0000_0001);
    for (int k = 31; k >= 0; k--) begin
      @(posedge linkClockLine);
      frame[k] = linkTransmitLine;
    end
    check("frame", frame[32:1], cmd);
    check("stop", 32'(frame[0]), ZERO);
    waitStatus(1, 32'h0000_0002, 30000, q);
    rd(`LSL_OFS_RX, q);
    check("reply", q, {2'b10, 2'b10, REPLY});
    rd(`LSL_OFS_RX, q);
    check("rx cleared", q, ZERO);
    rd(`LSL_OFS_STATUS, q);
    check("ready cleared", q, ZERO);
  endtask : testHkReply
  task automatic testTimeout();
    lsl_word_t q;
    silent = 1'b1;
    wrTx({2'b10, 2'b00, 28'h000_00AB});
    waitStatus(3, 32'h0000_0008, 30000, q);
    rd(`LSL_OFS_STATUS, q);
    check("timeout cleared", q, ZERO);
  endtask : testTimeout
  task automatic testLinkReset();
    lsl_word_t q;
    // a second request while the first is still unsent cancels it
    wrTx({2'b10, 2'b11, 28'hFFF_FF00});
    wrTx({2'b10, 2'b11, 28'hFFF_FFFF});
    rd(`LSL_OFS_STATUS, q);
    check("aborted", q, 32'h0000_0010);
    waitStatus(0, 32'h0000_0001, 2000, q);
    repeat (3) @(posedge linkClockLine);
    @(posedge clk_sys);
    linkResetFlag <= 1'b1;
    repeat (4) @(posedge clk_sys);
    rd(`LSL_OFS_STATUS, q);
    check("status reset", q, ZERO);
    check("lines reset", 32'({linkClockLine, linkTransmitLine}), ZERO);
    rd(`LSL_OFS_TX, q);
    check("tx reset", q, ZERO);
    @(posedge clk_sys);
    linkResetFlag <= 1'b0;
  endtask : testLinkReset
  ////////////////////////////////////////
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : summarize
  initial begin
    repeat (4) @(posedge clk_sys);
    rst_b <= 1'b1;
    testRegsAfterReset();
    testHkReply();
    testTimeout();
    testLinkReset();
    summarize();
  end
  initial begin
    repeat (140000) @(posedge clk_sys);
    bad_count++;
    summarize();
  end
endmodule : tb_low_speed_command_link
